/* core/bwd_top.sv */
// breakpoint, watchpoint and debug entry capture unit with register port
`default_nettype none
module bwd_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [bwd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_q,
   input wire logic [31:0] ctx_pc,
   input wire logic [31:0] ctx_sp,
   input wire logic host_dbg_req,
   input wire logic debug_call_instruction_valid,
   input wire logic [bwd_pkg::THR_W-1:0] debug_call_instruction_thread,
   input wire logic pc_valid,
   input wire logic [31:0] pc_value,
   input wire logic [bwd_pkg::THR_W-1:0] pc_thread,
   input wire logic mem_valid,
   input wire logic [31:0] mem_addr,
   input wire logic mem_load,
   input wire logic [bwd_pkg::THR_W-1:0] mem_thread,
   input wire logic res_valid,
   input wire logic [31:0] res_id,
   input wire logic [bwd_pkg::THR_W-1:0] res_thread,
   input wire logic debug_return,
   output logic debug_enter_q,
   output logic debug_mode_q,
   output logic [bwd_pkg::N_THR-1:0] thread_hold_q,
   output logic [7:0] rr_thread_q,
   output logic [bwd_pkg::RR_INDEX_W-1:0] rr_index_q
);
   // true when idx names slot 'slot' of the bank starting at 'base'
   function automatic logic at_reg(input logic [7:0] idx,
                                   input logic [7:0] base,
                                   input logic [2:0] slot);
      return idx == (base + {5'h00, slot});
   endfunction

   // true when idx falls in a bank of four or eight at 'base'
   function automatic logic in_bank(input logic [7:0] idx,
                                    input logic [7:0] base,
                                    input logic wide);
      return wide ? (idx[7:3] == base[7:3]) : (idx[7:2] == base[7:2]);
   endfunction

   // lowest set bit of a four-wide hit vector
   function automatic logic [1:0] first_hit(input logic [3:0] h);
      return h[0] ? 2'd0 : (h[1] ? 2'd1 : (h[2] ? 2'd2 : 2'd3));
   endfunction

   logic [7:0] idx;
   assign idx = reg_addr[9:2];

   bwd_pkg::bwd_state_t state_q;
   bwd_pkg::bwd_state_t state_d;

   logic [31:0] saved_pc_q;
   logic [31:0] saved_sp_q;
   logic [2:0] cause_q;
   logic [1:0] cause_idx_q;
   logic [7:0] cause_thr_q;
   logic [31:0] entry_data_q;
   logic [bwd_pkg::N_THR-1:0] stop_vec_q;
   logic [31:0] scratch_q [bwd_pkg::N_SCR];
   logic [31:0] code_addr_q [bwd_pkg::N_UNIT];
   logic [31:0] code_ctl_q [bwd_pkg::N_UNIT];
   logic [31:0] dw_addr_a_q [bwd_pkg::N_UNIT];
   logic [31:0] dw_addr_b_q [bwd_pkg::N_UNIT];
   logic [31:0] dw_ctl_q [bwd_pkg::N_UNIT];
   logic [31:0] rw_mask_q [bwd_pkg::N_UNIT];
   logic [31:0] rw_value_q [bwd_pkg::N_UNIT];
   logic [31:0] rw_ctl_q [bwd_pkg::N_UNIT];

   logic [3:0] code_hit;
   logic [3:0] data_hit;
   logic [3:0] res_hit;

   // scratch words: single storage, also what the tile side would see
   genvar s;
   generate
      for (s = 0; s < bwd_pkg::N_SCR; s++) begin : g_scr
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               scratch_q[s] <= bwd_pkg::WORD_RESET;
            end else if (reg_wr
                         && at_reg(idx, bwd_pkg::IDX_SCRATCH, 3'(s))) begin
               scratch_q[s] <= reg_wdata;
            end
         end
      end
   endgenerate

   genvar g;
   generate
      for (g = 0; g < bwd_pkg::N_UNIT; g++) begin : g_unit
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               code_addr_q[g] <= bwd_pkg::WORD_RESET;
               code_ctl_q[g] <= bwd_pkg::CTL_RESET;
               dw_addr_a_q[g] <= bwd_pkg::WORD_RESET;
               dw_addr_b_q[g] <= bwd_pkg::WORD_RESET;
               dw_ctl_q[g] <= bwd_pkg::CTL_RESET;
               rw_mask_q[g] <= bwd_pkg::WORD_RESET;
               rw_value_q[g] <= bwd_pkg::WORD_RESET;
               rw_ctl_q[g] <= bwd_pkg::CTL_RESET;
            end else if (reg_wr) begin
               if (at_reg(idx, bwd_pkg::IDX_CODE_ADDR, 3'(g))) begin
                  code_addr_q[g] <= reg_wdata;
               end
               if (at_reg(idx, bwd_pkg::IDX_CODE_CTL, 3'(g))) begin
                  code_ctl_q[g] <= reg_wdata & bwd_pkg::CODE_CTL_MASK;
               end
               if (at_reg(idx, bwd_pkg::IDX_DW_ADDR_A, 3'(g))) begin
                  dw_addr_a_q[g] <= reg_wdata;
               end
               if (at_reg(idx, bwd_pkg::IDX_DW_ADDR_B, 3'(g))) begin
                  dw_addr_b_q[g] <= reg_wdata;
               end
               if (at_reg(idx, bwd_pkg::IDX_DW_CTL, 3'(g))) begin
                  dw_ctl_q[g] <= reg_wdata & bwd_pkg::DW_CTL_MASK;
               end
               if (at_reg(idx, bwd_pkg::IDX_RW_MASK, 3'(g))) begin
                  rw_mask_q[g] <= reg_wdata;
               end
               if (at_reg(idx, bwd_pkg::IDX_RW_VALUE, 3'(g))) begin
                  rw_value_q[g] <= reg_wdata;
               end
               if (at_reg(idx, bwd_pkg::IDX_RW_CTL, 3'(g))) begin
                  rw_ctl_q[g] <= reg_wdata & bwd_pkg::RW_CTL_MASK;
               end
            end
         end

         bwd_unit #(
            .KIND(bwd_pkg::BWD_KIND_CODE)
         ) u_code (
            .ctl(code_ctl_q[g]),
            .valid(pc_valid),
            .thread(pc_thread),
            .cond_a(pc_value == code_addr_q[g]),
            .cond_b(1'b0),
            .is_load(1'b0),
            .hit(code_hit[g])
         );

         // range form: A is at or above address A, B at or below B
         bwd_unit #(
            .KIND(bwd_pkg::BWD_KIND_DATA)
         ) u_data (
            .ctl(dw_ctl_q[g]),
            .valid(mem_valid),
            .thread(mem_thread),
            .cond_a(mem_addr >= dw_addr_a_q[g]),
            .cond_b(mem_addr <= dw_addr_b_q[g]),
            .is_load(mem_load),
            .hit(data_hit[g])
         );

         bwd_unit #(
            .KIND(bwd_pkg::BWD_KIND_RES)
         ) u_res (
            .ctl(rw_ctl_q[g]),
            .valid(res_valid),
            .thread(res_thread),
            .cond_a(((res_id ^ rw_value_q[g]) & rw_mask_q[g])
                    == 32'h0000_0000),
            .cond_b(((res_id ^ rw_value_q[g]) & rw_mask_q[g])
                    != 32'h0000_0000),
            .is_load(1'b0),
            .hit(res_hit[g])
         );
      end
   endgenerate

   // entry arbitration: host first, then call, code, data, resource
   logic any_event;
   logic enter;
   logic [2:0] cause_sel;
   logic [1:0] idx_sel;
   logic [bwd_pkg::THR_W-1:0] thr_sel;
   logic [7:0] thr_field;
   logic take_data;

   assign any_event = host_dbg_req | debug_call_instruction_valid | (|code_hit)
      | (|data_hit) | (|res_hit);
   // events while already in debug mode are dropped
   assign enter = (state_q == bwd_pkg::BWD_ST_RUN) & any_event;

   assign cause_sel = host_dbg_req ? bwd_pkg::BWD_CAUSE_HOST
      : debug_call_instruction_valid ? bwd_pkg::BWD_CAUSE_CALL
      : (|code_hit) ? bwd_pkg::BWD_CAUSE_CODE
      : (|data_hit) ? bwd_pkg::BWD_CAUSE_DATA
      : bwd_pkg::BWD_CAUSE_RES;

   assign idx_sel = (host_dbg_req | debug_call_instruction_valid) ? 2'd0
      : (|code_hit) ? first_hit(code_hit)
      : (|data_hit) ? first_hit(data_hit)
      : first_hit(res_hit);

   assign thr_sel = debug_call_instruction_valid ? debug_call_instruction_thread
      : (|code_hit) ? pc_thread
      : (|data_hit) ? mem_thread
      : res_thread;
   assign thr_field = host_dbg_req ? 8'h00 : {5'h00, thr_sel};

   assign take_data = ~host_dbg_req & ~debug_call_instruction_valid & ~(|code_hit);

   assign state_d = enter ? bwd_pkg::BWD_ST_DEBUG
      : (debug_return ? bwd_pkg::BWD_ST_RUN : state_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= bwd_pkg::BWD_ST_RUN;
         debug_mode_q <= 1'b0;
         debug_enter_q <= 1'b0;
         thread_hold_q <= '0;
      end else begin
         state_q <= state_d;
         debug_mode_q <= (state_d == bwd_pkg::BWD_ST_DEBUG);
         debug_enter_q <= enter;
         // hold follows the mode being entered, so all threads are freed in the same cycle as entry
         thread_hold_q <= (state_d == bwd_pkg::BWD_ST_DEBUG)
            ? '0 : stop_vec_q;
      end
   end

   // entry capture wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         saved_pc_q <= bwd_pkg::WORD_RESET;
         saved_sp_q <= bwd_pkg::WORD_RESET;
         cause_q <= bwd_pkg::BWD_CAUSE_NONE;
         cause_idx_q <= 2'd0;
         cause_thr_q <= 8'h00;
         entry_data_q <= bwd_pkg::WORD_RESET;
      end else if (enter) begin
         saved_pc_q <= ctx_pc;
         saved_sp_q <= ctx_sp;
         cause_q <= cause_sel;
         cause_idx_q <= idx_sel;
         cause_thr_q <= thr_field;
         if (take_data) begin
            entry_data_q <= (|data_hit) ? mem_addr : res_id;
         end
      end else if (reg_wr) begin
         if (idx == bwd_pkg::IDX_SAVED_PC) begin
            saved_pc_q <= reg_wdata;
         end
         if (idx == bwd_pkg::IDX_SAVED_SP) begin
            saved_sp_q <= reg_wdata;
         end
         if (idx == bwd_pkg::IDX_CAUSE) begin
            cause_q <= reg_wdata[bwd_pkg::CAUSE_KIND_LSB +: 3];
            cause_idx_q <= reg_wdata[bwd_pkg::CAUSE_IDX_LSB +: 2];
            cause_thr_q <= reg_wdata[bwd_pkg::CAUSE_THR_LSB +: 8];
         end
         if (idx == bwd_pkg::IDX_ENTRY_DATA) begin
            entry_data_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rr_thread_q <= 8'h00;
         rr_index_q <= '0;
         stop_vec_q <= '0;
      end else if (reg_wr) begin
         if (idx == bwd_pkg::IDX_RR_THREAD) begin
            rr_thread_q <= reg_wdata[7:0];
         end
         if (idx == bwd_pkg::IDX_RR_INDEX) begin
            rr_index_q <= reg_wdata[bwd_pkg::RR_INDEX_W-1:0];
         end
         if (idx == bwd_pkg::IDX_STOP_VEC) begin
            stop_vec_q <= reg_wdata[bwd_pkg::N_THR-1:0];
         end
      end
   end

   // read selection; unmapped indices read as zero
   logic [31:0] cause_word;
   logic [31:0] rd_val;
   logic [1:0] slot4;
   logic [2:0] slot8;

   assign slot4 = idx[1:0];
   assign slot8 = idx[2:0];
   assign cause_word = {14'h0000, cause_idx_q, cause_thr_q,
                        5'h00, cause_q};

   assign rd_val =
      (idx == bwd_pkg::IDX_SAVED_PC) ? saved_pc_q
      : (idx == bwd_pkg::IDX_SAVED_SP) ? saved_sp_q
      : (idx == bwd_pkg::IDX_RR_THREAD) ? {24'h00_0000, rr_thread_q}
      : (idx == bwd_pkg::IDX_RR_INDEX) ? {27'h000_0000, rr_index_q}
      : (idx == bwd_pkg::IDX_CAUSE) ? cause_word
      : (idx == bwd_pkg::IDX_ENTRY_DATA) ? entry_data_q
      : (idx == bwd_pkg::IDX_STOP_VEC) ? {24'h00_0000, stop_vec_q}
      : in_bank(idx, bwd_pkg::IDX_SCRATCH, 1'b1) ? scratch_q[slot8]
      : in_bank(idx, bwd_pkg::IDX_CODE_ADDR, 1'b0) ? code_addr_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_CODE_CTL, 1'b0) ? code_ctl_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_DW_ADDR_A, 1'b0) ? dw_addr_a_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_DW_ADDR_B, 1'b0) ? dw_addr_b_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_DW_CTL, 1'b0) ? dw_ctl_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_RW_MASK, 1'b0) ? rw_mask_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_RW_VALUE, 1'b0) ? rw_value_q[slot4]
      : in_bank(idx, bwd_pkg::IDX_RW_CTL, 1'b0) ? rw_ctl_q[slot4]
      : 32'h0000_0000;

   // data valid only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= reg_rd ? rd_val : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

/* core/bwd_pkg.sv */
// constants and types shared by the breakpoint and watchpoint debug unit
`default_nettype none
package bwd_pkg;
   localparam int unsigned N_UNIT = 4;
   localparam int unsigned N_THR = 8;
   localparam int unsigned N_SCR = 8;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned THR_W = 3;
   localparam int unsigned CLK_MHZ = 125;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SAVED_PC = 8'h11;
   localparam logic [7:0] IDX_SAVED_SP = 8'h12;
   localparam logic [7:0] IDX_RR_THREAD = 8'h13;
   localparam logic [7:0] IDX_RR_INDEX = 8'h14;
   localparam logic [7:0] IDX_CAUSE = 8'h15;
   localparam logic [7:0] IDX_ENTRY_DATA = 8'h16;
   localparam logic [7:0] IDX_STOP_VEC = 8'h18;
   localparam logic [7:0] IDX_SCRATCH = 8'h20;
   localparam logic [7:0] IDX_CODE_ADDR = 8'h30;
   localparam logic [7:0] IDX_CODE_CTL = 8'h40;
   localparam logic [7:0] IDX_DW_ADDR_A = 8'h50;
   localparam logic [7:0] IDX_DW_ADDR_B = 8'h60;
   localparam logic [7:0] IDX_DW_CTL = 8'h70;
   localparam logic [7:0] IDX_RW_MASK = 8'h80;
   localparam logic [7:0] IDX_RW_VALUE = 8'h90;
   localparam logic [7:0] IDX_RW_CTL = 8'h9C;

   // control word fields
   localparam int unsigned CTL_EN_BIT = 0;
   localparam int unsigned CTL_SEL_BIT = 1;
   localparam int unsigned CTL_LOAD_BIT = 2;
   localparam int unsigned CTL_THR_LSB = 16;
   localparam logic [31:0] CODE_CTL_MASK = 32'h00ff_0003;
   localparam logic [31:0] DW_CTL_MASK = 32'h00ff_0007;
   localparam logic [31:0] RW_CTL_MASK = 32'h00ff_0003;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   // cause register fields and remote read index width
   localparam int unsigned CAUSE_KIND_LSB = 0;
   localparam int unsigned CAUSE_THR_LSB = 8;
   localparam int unsigned CAUSE_IDX_LSB = 16;
   localparam int unsigned RR_INDEX_W = 5;

   typedef enum logic [2:0] {
      BWD_CAUSE_NONE = 3'b000,
      BWD_CAUSE_HOST = 3'b001,
      BWD_CAUSE_CALL = 3'b010,
      BWD_CAUSE_CODE = 3'b011,
      BWD_CAUSE_DATA = 3'b100,
      BWD_CAUSE_RES = 3'b101
   } bwd_cause_t;

   typedef enum logic [0:0] {
      BWD_ST_RUN = 1'b0,
      BWD_ST_DEBUG = 1'b1
   } bwd_state_t;

   typedef enum logic [1:0] {
      BWD_KIND_CODE = 2'b00,
      BWD_KIND_DATA = 2'b01,
      BWD_KIND_RES = 2'b10
   } bwd_kind_t;
endpackage
`default_nettype wire

/* core/bwd_unit.sv */
// one breakpoint or watchpoint trigger, shaped by its control word
`default_nettype none
module bwd_unit #(
   parameter bwd_pkg::bwd_kind_t KIND = bwd_pkg::BWD_KIND_CODE
) (
   input wire logic [31:0] ctl,
   input wire logic valid,
   input wire logic [bwd_pkg::THR_W-1:0] thread,
   input wire logic cond_a,
   input wire logic cond_b,
   input wire logic is_load,
   output logic hit
);
   logic en;
   logic sel;
   logic thr_ok;
   logic match;
   logic [bwd_pkg::N_THR-1:0] thr_en;

   assign en = ctl[bwd_pkg::CTL_EN_BIT];
   assign sel = ctl[bwd_pkg::CTL_SEL_BIT];
   assign thr_en = ctl[bwd_pkg::CTL_THR_LSB +: bwd_pkg::N_THR];
   assign thr_ok = thr_en[thread];

   generate
      if (KIND == bwd_pkg::BWD_KIND_CODE) begin : g_code
         assign match = cond_a ^ sel;
      end else if (KIND == bwd_pkg::BWD_KIND_DATA) begin : g_data
         // stores always qualify; loads only when allowed
         assign match = (sel ? (cond_a | cond_b) : (cond_a & cond_b))
            & (~is_load | ctl[bwd_pkg::CTL_LOAD_BIT]);
      end else begin : g_res
         assign match = sel ? cond_b : cond_a;
      end
   endgenerate

   assign hit = valid & en & thr_ok & match;
endmodule
`default_nettype wire

/* dv/bwd_top_properties.sv */
// concurrent checks on the debug unit ports, bound to the top module
`default_nettype none
module bwd_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [bwd_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic host_dbg_req,
   input wire logic debug_call_instruction_valid,
   input wire logic pc_valid,
   input wire logic mem_valid,
   input wire logic res_valid,
   input wire logic debug_return,
   input wire logic debug_enter_q,
   input wire logic debug_mode_q,
   input wire logic [bwd_pkg::N_THR-1:0] thread_hold_q,
   input wire logic [7:0] rr_thread_q,
   input wire logic [bwd_pkg::RR_INDEX_W-1:0] rr_index_q
);
   timeunit 1ns;
   timeprecision 1ps;
   logic no_evt;
   logic [7:0] wd_lo;
   logic [4:0] wd_idx;
   logic [7:0] wr_idx;
   assign no_evt = !(host_dbg_req | debug_call_instruction_valid | pc_valid | mem_valid
      | res_valid);
   assign wd_lo = reg_wdata[7:0];
   assign wd_idx = reg_wdata[4:0];
   assign wr_idx = reg_addr[9:2];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   enter_sets_mode_a: assert property (debug_enter_q |-> debug_mode_q)
      else $error("entry pulse without debug mode");
   enter_single_a: assert property (debug_enter_q |=> !debug_enter_q)
      else $error("entry pulse longer than one cycle");
   host_entry_a: assert property (!debug_mode_q && host_dbg_req
      |=> debug_enter_q && debug_mode_q)
      else $error("host request did not enter debug");
   quiet_no_entry_a: assert property (!debug_mode_q && no_evt
      |=> !debug_enter_q)
      else $error("entry without any event");
   debug_frees_a: assert property (debug_mode_q |-> thread_hold_q == 8'h00)
      else $error("threads held while in debug mode");
   return_exit_a: assert property (debug_mode_q && debug_return
      |=> !debug_mode_q)
      else $error("debug mode kept after return");
   mode_stays_a: assert property (debug_mode_q && !debug_return
      |=> debug_mode_q && !debug_enter_q)
      else $error("debug mode left or reentered");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
      else $error("read data outside its cycle");
   rr_thread_a: assert property (reg_wr && wr_idx == 8'h13
      |=> rr_thread_q == $past(wd_lo))
      else $error("remote read thread operand not taken");
   rr_index_a: assert property (reg_wr && wr_idx == 8'h14
      |=> rr_index_q == $past(wd_idx))
      else $error("remote read index operand not taken");
   cover property (!debug_mode_q && host_dbg_req ##1 debug_enter_q);
   cover property (!debug_mode_q && pc_valid ##1 debug_enter_q);
   cover property (debug_mode_q && debug_return);
endmodule
bind bwd_top bwd_checker i_bwd_checker (.clk, .rst_b, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata_q, .host_dbg_req, .debug_call_instruction_valid, .pc_valid,
   .mem_valid, .res_valid, .debug_return, .debug_enter_q, .debug_mode_q,
   .thread_hold_q, .rr_thread_q, .rr_index_q);
`default_nettype wire

/* dv/bwd_core_model.sv */
// behavioural core pipeline that issues debug events and returns
`default_nettype none
module bwd_core_model (
   input wire logic clk,
   output logic [31:0] ctx_pc,
   output logic [31:0] ctx_sp,
   output logic host_dbg_req,
   output logic debug_call_instruction_valid,
   output logic [2:0] debug_call_instruction_thread,
   output logic pc_valid,
   output logic [31:0] pc_value,
   output logic [2:0] pc_thread,
   output logic mem_valid,
   output logic [31:0] mem_addr,
   output logic mem_load,
   output logic [2:0] mem_thread,
   output logic res_valid,
   output logic [31:0] res_id,
   output logic [2:0] res_thread,
   output logic debug_return
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {host_dbg_req, debug_call_instruction_valid, pc_valid, mem_valid, res_valid} = '0;
      {mem_load, debug_return, ctx_pc, ctx_sp, pc_value, mem_addr} = '0;
      {res_id, debug_call_instruction_thread, pc_thread, mem_thread, res_thread} = '0;
   end
   // kind 0 host, 1 debug call, 2 issue, 3 memory, 4 resource
   task automatic fire(input int k, input logic [31:0] v,
         input logic [2:0] t, input logic ld);
      @(posedge clk);
      ctx_pc <= ~v;
      ctx_sp <= {v[15:0], v[31:16]};
      host_dbg_req <= (k == 0);
      debug_call_instruction_valid <= (k == 1);
      pc_valid <= (k == 2);
      mem_valid <= (k == 3);
      res_valid <= (k == 4);
      debug_call_instruction_thread <= t;
      pc_thread <= t;
      mem_thread <= t;
      res_thread <= t;
      pc_value <= v;
      mem_addr <= v;
      res_id <= v;
      mem_load <= ld;
      @(posedge clk);
      {host_dbg_req, debug_call_instruction_valid, pc_valid, mem_valid, res_valid} <= '0;
      // released value lines must not keep looking valid
      pc_value <= ~v;
      mem_addr <= ~v;
      res_id <= ~v;
   endtask
   task automatic ret();
      @(posedge clk);
      debug_return <= 1'b1;
      @(posedge clk);
      debug_return <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the breakpoint and watchpoint debug unit
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [bwd_pkg::ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata_q, ctx_pc, ctx_sp, pc_value, mem_addr, res_id;
   logic host_dbg_req, debug_call_instruction_valid, pc_valid, mem_valid, mem_load;
   logic res_valid, debug_return, debug_enter_q, debug_mode_q;
   logic [2:0] debug_call_instruction_thread, pc_thread, mem_thread, res_thread;
   logic [7:0] thread_hold_q, rr_thread_q;
   logic [4:0] rr_index_q;
   logic [31:0] last_data = 32'h0000_0000;
   logic [7:0] stop_v = 8'h24;
   logic [7:0] cidx [3] = '{8'h41, 8'h72, 8'h9F};
   logic [31:0] cmask [3] = '{32'h00ff_0003, 32'h00ff_0007, 32'h00ff_0003};
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   bwd_top i_bwd_top (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q, .ctx_pc, .ctx_sp, .host_dbg_req, .debug_call_instruction_valid,
      .debug_call_instruction_thread, .pc_valid, .pc_value, .pc_thread, .mem_valid, .mem_addr,
      .mem_load, .mem_thread, .res_valid, .res_id, .res_thread, .debug_return,
      .debug_enter_q, .debug_mode_q, .thread_hold_q, .rr_thread_q, .rr_index_q);
   bwd_core_model i_bwd_core_model (.clk, .ctx_pc, .ctx_sp, .host_dbg_req,
      .debug_call_instruction_valid, .debug_call_instruction_thread, .pc_valid, .pc_value, .pc_thread,
      .mem_valid, .mem_addr, .mem_load, .mem_thread, .res_valid, .res_id,
      .res_thread, .debug_return);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= {idx, 2'b00};
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= {idx, 2'b00};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check(reg_rdata_q, exp);
   endtask
   // one event; on a hit the full capture is read back and debug is left
   task automatic trig(input int k, input logic [31:0] v, input logic [2:0] t,
         input logic ld, input logic hit, input logic [31:0] cause);
      i_bwd_core_model.fire(k, v, t, ld);
      #1;
      check({31'h0, debug_enter_q}, {31'h0, hit});
      if (hit) begin
         if (k >= 3) last_data = v;
         rd(8'h15, cause);
         rd(8'h16, last_data);
         rd(8'h11, ~v);
         rd(8'h12, {v[15:0], v[31:16]});
         check({24'h0, thread_hold_q}, 32'h0000_0000);
         i_bwd_core_model.ret();
         #1;
         check({31'h0, debug_mode_q}, 32'h0000_0000);
         check({24'h0, thread_hold_q}, {24'h0, stop_v});
      end
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(8'h15, 32'h0000_0000);
      rd(8'h42, 32'h0000_0000);
      rd(8'h71, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         wr(8'h20 + 8'(i), 32'hC0DE_0000 + i);
      end
      for (int i = 0; i < 8; i++) begin
         rd(8'h20 + 8'(i), 32'hC0DE_0000 + i);
      end
      wr(8'h17, 32'hFFFF_FFFF);
      rd(8'h17, 32'h0000_0000);
      foreach (cidx[k]) begin
         wr(cidx[k], 32'hFFFF_FFFF);
         rd(cidx[k], cmask[k]);
         wr(cidx[k], 32'h0000_0000);
      end
      wr(8'h13, 32'hFFFF_FFAB);
      rd(8'h13, 32'h0000_00AB);
      check({24'h0, rr_thread_q}, 32'h0000_00AB);
      wr(8'h14, 32'hFFFF_FFFF);
      rd(8'h14, 32'h0000_001F);
      check({27'h0, rr_index_q}, 32'h0000_001F);
      wr(8'h18, {24'hFF_FFFF, stop_v});
      rd(8'h18, {24'h0, stop_v});
      check({24'h0, thread_hold_q}, {24'h0, stop_v});
      trig(0, 32'h1357_9BDF, 3'd6, 1'b0, 1'b1, 32'h0000_0001);
      trig(1, 32'h2468_ACE0, 3'd5, 1'b0, 1'b1, 32'h0000_0502);
      wr(8'h32, 32'h0000_4000);
      wr(8'h33, 32'h0000_4000);
      wr(8'h42, 32'h0004_0001);
      wr(8'h43, 32'h0004_0001);
      trig(2, 32'h0000_4000, 3'd2, 1'b0, 1'b1, 32'h0002_0203);
      trig(2, 32'h0000_4000, 3'd3, 1'b0, 1'b0, 32'h0);
      trig(2, 32'h0000_4004, 3'd2, 1'b0, 1'b0, 32'h0);
      wr(8'h42, 32'h0004_0000);
      wr(8'h43, 32'h0004_0000);
      trig(2, 32'h0000_4000, 3'd2, 1'b0, 1'b0, 32'h0);
      wr(8'h30, 32'h0000_4000);
      wr(8'h40, 32'h0004_0003);
      trig(2, 32'h0000_4004, 3'd2, 1'b0, 1'b1, 32'h0000_0203);
      wr(8'h40, 32'h0000_0000);
      wr(8'h51, 32'h0000_0100);
      wr(8'h61, 32'h0000_01FF);
      wr(8'h71, 32'h0002_0001);
      trig(3, 32'h0000_0180, 3'd1, 1'b0, 1'b1, 32'h0001_0104);
      trig(3, 32'h0000_0050, 3'd1, 1'b0, 1'b0, 32'h0);
      trig(3, 32'h0000_0180, 3'd1, 1'b1, 1'b0, 32'h0);
      wr(8'h71, 32'h0002_0007);
      trig(3, 32'h0000_0050, 3'd1, 1'b1, 1'b1, 32'h0001_0104);
      wr(8'h71, 32'h0000_0000);
      wr(8'h80, 32'hFFFF_0000);
      wr(8'h90, 32'h1234_0000);
      wr(8'h9C, 32'h0080_0001);
      trig(4, 32'h1234_ABCD, 3'd7, 1'b0, 1'b1, 32'h0000_0705);
      trig(4, 32'h1235_ABCD, 3'd7, 1'b0, 1'b0, 32'h0);
      wr(8'h9C, 32'h0080_0003);
      trig(4, 32'h1235_ABCD, 3'd7, 1'b0, 1'b1, 32'h0000_0705);
      i_bwd_core_model.fire(0, 32'h0000_0001, 3'd0, 1'b0);
      i_bwd_core_model.fire(1, 32'h0000_0002, 3'd3, 1'b0);
      #1;
      check({31'h0, debug_enter_q}, 32'h0000_0000);
      rd(8'h15, 32'h0000_0001);
      i_bwd_core_model.ret();
      complete_run();
   end
endmodule
`default_nettype wire
